// >>> standby_pkg.sv
package standby_pkg;

    // Source indices: seven interrupt sources, then two test sources
    localparam int NUM_SRC = 9;
    localparam int SRC_BT = 0;
    localparam int SRC_FILT = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_EXT4 = 3;
    localparam int SRC_SER = 4;
    localparam int SRC_TEV = 5;
    localparam int SRC_TCNT = 6;
    localparam int SRC_DUAL = 7;
    localparam int SRC_CLKT = 8;

    // Register byte addresses
    localparam logic [11:0] ADDR_REQ = 12'h000;
    localparam logic [11:0] ADDR_EN = 12'h004;
    localparam logic [11:0] ADDR_CTRL = 12'h008;
    localparam logic [11:0] ADDR_PRIO = 12'h00c;
    localparam logic [11:0] ADDR_EDGE = 12'h010;
    localparam logic [11:0] ADDR_STAT = 12'h014;
    localparam logic [11:0] ADDR_VEC_BASE = 12'h040;

    // Field positions
    localparam int CTRL_MIE = 0;
    localparam int CTRL_SER_EXT = 1;
    localparam int CTRL_TEV_PIN = 2;
    localparam int CTRL_CLKT_SUB = 3;
    localparam int CTRL_WDT = 4;
    localparam int EDGE_BYPASS = 2;

    // Reset values
    localparam logic [8:0] EN_RESET = 9'h000;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [8:0] PRIO_RESET = 9'h000;
    localparam logic [3:0] EDGE_RESET = 4'h0;
    localparam logic [15:0] VEC_RESET = 16'h0000;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_HALT,
        MODE_STOP
    } power_mode_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic main_osc_en;
        logic bt_run;
        logic ser_run;
        logic tev_run;
        logic tcnt_run;
        logic clkt_run;
        logic filt_run;
    } run_enables_t;

    typedef struct packed {
        logic valid;
        logic [3:0] src;
        logic [15:0] vector;
    } irq_take_t;

endpackage

// >>> edge_catch.sv
`timescale 1ns/1ps

module edge_catch #(
    parameter int WIDTH = 2
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pin,
    input wire logic [WIDTH-1:0] pin_en,
    input wire logic [WIDTH-1:0] rise_sel,
    output logic hit
);
    logic [WIDTH-1:0] last;
    logic [WIDTH-1:0] seen;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            last <= '0;
        end else begin
            last <= pin;
        end
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_edge
        assign seen[i] = pin_en[i] & (rise_sel[i] ? (pin[i] & ~last[i]) : (~pin[i] & last[i]));
    end

    assign hit = |seen;
endmodule

// >>> standby_wakeup_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) Seven interrupt, two test sources, flags each
// (RULE2) Vector taken only when source and master enabled
// (RULE3) Each source's start address is programmable
// (RULE4) Priority register lets high sources nest
// (RULE5) Software reads and clears every request flag
// (RULE6) Enabled sources alone may release standby
// (RULE7) Dual-edge test source watches two pins
// (RULE8) Filter selected: filtered input cannot wake
// (RULE9) STOP only on main clock; HALT either
// (RULE10) STOP stops main oscillator and CPU
// (RULE11) HALT gates CPU clock only
// (RULE12) Basic timer: off in STOP, HALT needs main
// (RULE13) In HALT basic timer flags or resets
// (RULE14) Serial: STOP external clock; HALT also internal
// (RULE15) Event counter: STOP pin clock; HALT also internal
// (RULE16) Second timer: off in STOP, HALT needs main
// (RULE17) Clock timer: HALT runs; STOP needs subclock
// (RULE18) Standby keeps unfiltered inputs, drops filtered
// (RULE19) Filtered input works in standby if bypass set
// (RULE20) Enabled request or reset releases standby

module standby_wakeup_control (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_cmd,
    input wire logic halt_cmd,
    input wire logic on_subclock,
    input wire logic filtered_ext_interrupt,
    input wire logic filtered_ext_clean,
    input wire logic ext_interrupt_one,
    input wire logic ext_interrupt_four,
    input wire logic [1:0] dual_edge_test_source,
    input wire logic bt_interval_tick,
    input wire logic bt_overflow,
    input wire logic ser_done,
    input wire logic tev_match,
    input wire logic tcnt_match,
    input wire logic clkt_tick,
    input wire logic irq_ack,
    input wire logic irq_return,
    output standby_pkg::irq_take_t irq_take,
    output standby_pkg::power_mode_t power_mode,
    output standby_pkg::run_enables_t run_en,
    output logic watchdog_reset,
    output logic stop_refused
);
    localparam int N = standby_pkg::NUM_SRC;

    logic [N-1:0] source_request_flag;
    logic [N-1:0] source_enable_flag;
    logic [N-1:0] priority_select_register;
    logic [4:0] ctrl;
    logic [3:0] edge_mode_register;
    logic [15:0] vec_addr [N];
    logic [N-1:0] raw_event;
    logic [N-1:0] clr_mask;
    logic [N-1:0] pending;
    logic [N-1:0] wake_src;
    logic dual_hit;
    logic master_interrupt_enable;
    logic noise_filter_bypass_bit;
    logic in_standby;
    logic main_osc;
    logic wake;
    logic in_service;
    logic in_service_high;
    logic [3:0] pick;
    logic pick_valid;
    logic wr;
    logic rd;
    logic [31:0] next_prdata;
    logic next_slverr;
    logic filt_event;

    assign master_interrupt_enable = ctrl[standby_pkg::CTRL_MIE];
    assign noise_filter_bypass_bit = edge_mode_register[standby_pkg::EDGE_BYPASS];
    assign in_standby = power_mode != standby_pkg::MODE_RUN;
    assign main_osc = power_mode != standby_pkg::MODE_STOP;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    // Zero-wait slave
    assign pready = 1'b1;

    edge_catch #(
        .WIDTH(2)
    ) u_dual (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin(dual_edge_test_source),
        .pin_en(edge_mode_register[1:0] | 2'h3),
        .rise_sel({edge_mode_register[1], edge_mode_register[0]}),
        .hit(dual_hit)
    );

    // Filtered input dead in standby unless the filter is bypassed
    always_comb begin
        filt_event = noise_filter_bypass_bit ? filtered_ext_interrupt : filtered_ext_clean; // RULE19
        if (in_standby && !noise_filter_bypass_bit) begin
            filt_event = 1'b0; // RULE18 RULE8
        end
    end

    // Peripheral run permissions by mode
    always_comb begin
        run_en.cpu_clk_en = power_mode == standby_pkg::MODE_RUN; // RULE11 RULE10
        run_en.main_osc_en = main_osc; // RULE10
        run_en.bt_run = main_osc; // RULE12
        run_en.ser_run = !in_standby || main_osc || ctrl[standby_pkg::CTRL_SER_EXT]; // RULE14
        run_en.tev_run = main_osc || ctrl[standby_pkg::CTRL_TEV_PIN]; // RULE15
        run_en.tcnt_run = main_osc; // RULE16
        run_en.clkt_run = main_osc || ctrl[standby_pkg::CTRL_CLKT_SUB]; // RULE17
        run_en.filt_run = !in_standby || noise_filter_bypass_bit; // RULE18
    end

    always_comb begin
        raw_event = '0;
        raw_event[standby_pkg::SRC_BT] = bt_interval_tick & run_en.bt_run
            & ~ctrl[standby_pkg::CTRL_WDT]; // RULE13
        raw_event[standby_pkg::SRC_FILT] = filt_event;
        raw_event[standby_pkg::SRC_EXT1] = ext_interrupt_one; // RULE18
        raw_event[standby_pkg::SRC_EXT4] = ext_interrupt_four; // RULE18
        raw_event[standby_pkg::SRC_SER] = ser_done & run_en.ser_run;
        raw_event[standby_pkg::SRC_TEV] = tev_match & run_en.tev_run;
        raw_event[standby_pkg::SRC_TCNT] = tcnt_match & run_en.tcnt_run;
        raw_event[standby_pkg::SRC_DUAL] = dual_hit; // RULE7
        raw_event[standby_pkg::SRC_CLKT] = clkt_tick & run_en.clkt_run;
    end

    // Watchdog overflow resets the core only while the counter may run
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_reset <= 1'b0;
        end else begin
            watchdog_reset <= bt_overflow & run_en.bt_run & ctrl[standby_pkg::CTRL_WDT]; // RULE13
        end
    end

    always_comb begin
        clr_mask = '0;
        if (wr && paddr == standby_pkg::ADDR_REQ) begin
            clr_mask = pwdata[N-1:0]; // RULE5
        end
        if (irq_ack && irq_take.valid && irq_take.src < 4'(N)) begin
            clr_mask[irq_take.src] = 1'b1;
        end
    end

    // Set beats clear so an event coinciding with a clear survives
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            source_request_flag <= '0;
        end else begin
            source_request_flag <= (source_request_flag & ~clr_mask) | raw_event; // RULE1
        end
    end

    // Enables gate both acceptance and wake-up
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            source_enable_flag <= standby_pkg::EN_RESET;
        end else if (wr && paddr == standby_pkg::ADDR_EN) begin
            source_enable_flag <= pwdata[N-1:0]; // RULE1
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= standby_pkg::CTRL_RESET;
        end else if (wr && paddr == standby_pkg::ADDR_CTRL) begin
            ctrl <= pwdata[4:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            priority_select_register <= standby_pkg::PRIO_RESET;
        end else if (wr && paddr == standby_pkg::ADDR_PRIO) begin
            priority_select_register <= pwdata[N-1:0]; // RULE4
        end
    end

    // Polarity bits and filter bypass
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            edge_mode_register <= standby_pkg::EDGE_RESET;
        end else if (wr && paddr == standby_pkg::ADDR_EDGE) begin
            edge_mode_register <= pwdata[3:0];
        end
    end

    for (genvar i = 0; i < N; i++) begin : g_vec
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                vec_addr[i] <= standby_pkg::VEC_RESET;
            end else if (wr && paddr == standby_pkg::ADDR_VEC_BASE + 12'(4 * i)) begin
                vec_addr[i] <= pwdata[15:0]; // RULE3
            end
        end
    end

    // Acceptance and priority; high-priority sources may nest into low
    always_comb begin
        pending = source_request_flag & source_enable_flag;
        if (!master_interrupt_enable) begin
            pending = '0; // RULE2
        end else if (in_service_high) begin
            pending = '0; // RULE4
        end else if (in_service) begin
            pending = pending & priority_select_register; // RULE4
        end
        pick = 4'h0;
        pick_valid = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pending[i] && priority_select_register[i]) begin
                pick = 4'(i);
                pick_valid = 1'b1;
            end
        end
        if (!pick_valid) begin
            for (int i = N - 1; i >= 0; i--) begin
                if (pending[i]) begin
                    pick = 4'(i);
                    pick_valid = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_take <= '0;
        end else begin
            irq_take.valid <= pick_valid && !(irq_ack && irq_take.valid); // RULE2
            irq_take.src <= pick;
            irq_take.vector <= vec_addr[pick]; // RULE3
        end
    end

    // Two nesting levels: a high source may interrupt a low one only
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            in_service <= 1'b0;
            in_service_high <= 1'b0;
        end else if (irq_ack && irq_take.valid) begin
            if (priority_select_register[irq_take.src]) begin
                in_service_high <= 1'b1; // RULE4
            end else begin
                in_service <= 1'b1;
            end
        end else if (irq_return) begin
            // Return closes the innermost level unless an acknowledge lands in the same cycle
            if (in_service_high) begin
                in_service_high <= 1'b0;
            end else begin
                in_service <= 1'b0;
            end
        end
    end

    // Wake ignores master enable; only source enable counts
    always_comb begin
        wake_src = source_request_flag & source_enable_flag; // RULE6
        if (!noise_filter_bypass_bit) begin
            wake_src[standby_pkg::SRC_FILT] = 1'b0; // RULE8
        end
        wake = |wake_src; // RULE20
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            power_mode <= standby_pkg::MODE_RUN; // RULE20
        end else begin
            unique case (power_mode)
                standby_pkg::MODE_RUN: begin
                    if (stop_cmd && !on_subclock && !wake) begin
                        power_mode <= standby_pkg::MODE_STOP; // RULE9
                    end else if (halt_cmd && !stop_cmd && !wake) begin
                        power_mode <= standby_pkg::MODE_HALT; // RULE9
                    end
                end
                standby_pkg::MODE_HALT, standby_pkg::MODE_STOP: begin
                    if (wake) begin
                        power_mode <= standby_pkg::MODE_RUN; // RULE20
                    end
                end
                default: power_mode <= standby_pkg::MODE_RUN;
            endcase
        end
    end

    // STOP asked for on the subsystem clock is dropped and flagged
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stop_refused <= 1'b0;
        end else begin
            stop_refused <= stop_cmd && on_subclock // RULE9
                && power_mode == standby_pkg::MODE_RUN;
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        unique case (paddr)
            standby_pkg::ADDR_REQ: next_prdata[N-1:0] = source_request_flag; // RULE5
            standby_pkg::ADDR_EN: next_prdata[N-1:0] = source_enable_flag;
            standby_pkg::ADDR_CTRL: next_prdata[4:0] = ctrl;
            standby_pkg::ADDR_PRIO: next_prdata[N-1:0] = priority_select_register;
            standby_pkg::ADDR_EDGE: next_prdata[3:0] = edge_mode_register;
            standby_pkg::ADDR_STAT: next_prdata[3:0] = {in_service_high, in_service, power_mode};
            default: begin
                if (paddr >= standby_pkg::ADDR_VEC_BASE
                    && paddr < standby_pkg::ADDR_VEC_BASE + 12'(4 * N) && paddr[1:0] == 2'h0) begin
                    next_prdata[15:0] = vec_addr[4'((paddr - standby_pkg::ADDR_VEC_BASE) >> 2)];
                end else begin
                    next_slverr = 1'b1;
                end
            end
        endcase
    end

    // Read data held in a flop; sampled the access cycle it appears
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    assign pslverr = psel & penable & next_slverr;
endmodule

// >>> standby_monitor.sv
`timescale 1ns/1ps
module standby_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pslverr,
    input wire logic stop_cmd,
    input wire logic on_subclock,
    input wire logic bt_overflow,
    input wire logic irq_ack,
    input wire standby_pkg::irq_take_t irq_take,
    input wire standby_pkg::power_mode_t power_mode,
    input wire standby_pkg::run_enables_t run_en,
    input wire logic watchdog_reset,
    input wire logic stop_refused
);
    logic halt_m;
    logic stop_m;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    assign halt_m = power_mode == standby_pkg::MODE_HALT;
    assign stop_m = power_mode == standby_pkg::MODE_STOP;
    a_gap_error: assert property (
        psel && penable && paddr inside {[12'h018:12'h03c]} |-> pslverr)
        else $error("no error on unmapped address");
    a_halt_gate: assert property (
        halt_m |-> !run_en.cpu_clk_en && run_en.main_osc_en)
        else $error("halt clock gating wrong");
    a_stop_osc: assert property (
        stop_m |-> !run_en.cpu_clk_en && !run_en.main_osc_en)
        else $error("stop left a clock running");
    a_stop_timers: assert property (stop_m |-> !run_en.bt_run && !run_en.tcnt_run)
        else $error("timer running in stop");
    a_halt_periph: assert property (
        halt_m |-> run_en.bt_run && run_en.tcnt_run && run_en.ser_run
            && run_en.tev_run && run_en.clkt_run)
        else $error("peripheral stopped in halt");
    a_sub_stop: assert property (
        stop_cmd && on_subclock && power_mode == standby_pkg::MODE_RUN |=> !stop_m)
        else $error("stop entered from subclock");
    a_refuse_why: assert property (
        stop_refused |-> $past(stop_cmd) && $past(on_subclock))
        else $error("stop refused without cause");
    a_ack_drop: assert property (irq_ack && irq_take.valid |=> !irq_take.valid)
        else $error("pick held after acknowledge");
    a_wdt_cause: assert property (
        watchdog_reset |-> $past(bt_overflow) && $past(power_mode) != standby_pkg::MODE_STOP)
        else $error("watchdog reset without overflow");
endmodule
bind standby_wakeup_control standby_monitor mon (.clk_sys, .rst_b, .psel, .penable, .paddr,
    .pslverr, .stop_cmd, .on_subclock, .bt_overflow, .irq_ack, .irq_take, .power_mode,
    .run_en, .watchdog_reset, .stop_refused);

// >>> cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic want_stop,
    input wire logic want_halt,
    input wire logic [3:0] ack_wait,
    input wire standby_pkg::irq_take_t irq_take,
    output logic stop_cmd,
    output logic halt_cmd,
    output logic irq_ack,
    output logic irq_return
);
    logic [3:0] wait_cnt;
    logic [3:0] svc_cnt;
    // Standby instructions are single-cycle pulses
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stop_cmd <= 1'b0;
            halt_cmd <= 1'b0;
        end else begin
            stop_cmd <= want_stop;
            halt_cmd <= want_halt;
        end
    end
    // Slow acceptance when ack_wait is large
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= 4'h0;
            irq_ack <= 1'b0;
            svc_cnt <= 4'h0;
            irq_return <= 1'b0;
        end else begin
            irq_ack <= 1'b0;
            irq_return <= svc_cnt == 4'h1;
            if (svc_cnt != 4'h0) begin
                svc_cnt <= svc_cnt - 4'h1;
            end
            if (irq_take.valid && !irq_ack) begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt >= ack_wait) begin
                    irq_ack <= 1'b1;
                    wait_cnt <= 4'h0;
                    svc_cnt <= 4'h6;
                end
            end
        end
    end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, rst_b, psel, penable, pwrite, pslverr, pready, on_subclock;
    logic stop_w, halt_w, stop_cmd, halt_cmd, irq_ack, irq_return, wd_rst, refused;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] ev;
    logic [1:0] pins;
    logic [3:0] ack_w;
    standby_pkg::irq_take_t irq_take;
    standby_pkg::power_mode_t power_mode;
    standby_pkg::run_enables_t run_en;
    int mismatches, n_checks;
    standby_wakeup_control dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .stop_cmd, .halt_cmd, .on_subclock,
        .filtered_ext_interrupt(ev[7]), .filtered_ext_clean(ev[1]), .ext_interrupt_one(ev[2]),
        .ext_interrupt_four(ev[3]), .dual_edge_test_source(pins), .bt_interval_tick(ev[0]),
        .bt_overflow(ev[9]), .ser_done(ev[4]), .tev_match(ev[5]), .tcnt_match(ev[6]),
        .clkt_tick(ev[8]), .irq_ack, .irq_return, .irq_take, .power_mode, .run_en,
        .watchdog_reset(wd_rst), .stop_refused(refused));
    cpu_model partner (.clk_sys, .rst_b, .want_stop(stop_w), .want_halt(halt_w),
        .ack_wait(ack_w), .irq_take, .stop_cmd, .halt_cmd, .irq_ack, .irq_return);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            print_verdict();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk("read data", q, exp);
    endtask
    // Event pulse, then room for flag set and wake
    task automatic pulse(input logic [9:0] m);
        ev <= m;
        @(posedge clk_sys);
        ev <= 10'h000;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic cmd(input logic s, input logic h, output logic r);
        stop_w <= s;
        halt_w <= h;
        @(posedge clk_sys);
        stop_w <= 1'b0;
        halt_w <= 1'b0;
        r = 1'b0;
        repeat (4) begin
            @(posedge clk_sys);
            r = r | refused;
        end
    endtask
    task automatic mode_is(input standby_pkg::power_mode_t m);
        chk("mode", 32'(power_mode), 32'(m));
    endtask
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        rd(12'h004, 32'h0);
        rd(12'h008, 32'h0);
        rd(12'h00c, 32'h0);
        rd(12'h010, 32'h0);
        rd(12'h044, 32'h0);
        wr(12'h004, 32'hffff_ffff);
        rd(12'h004, 32'h1ff);
        apb(1'b0, 12'h020, 32'h0, q, e);
        chk("unmapped", {q[30:0], e}, 32'h1);
    endtask
    task automatic t_flags();
        wr(12'h010, 32'h3);
        pins <= 2'b01;
        pulse(10'h17f);
        rd(12'h000, 32'h1ff);
        chk("no pick", 32'(irq_take.valid), 32'h0);
        wr(12'h000, 32'h1ff);
        rd(12'h000, 32'h0);
        pins <= 2'b11;
        pulse(10'h000);
        rd(12'h000, 32'h080);
        wr(12'h000, 32'h1ff);
        pins <= 2'b00;
        pulse(10'h000);
        rd(12'h000, 32'h0);
    endtask
    task automatic t_vector();
        int n;
        ack_w <= 4'h3;
        wr(12'h048, 32'h1234);
        wr(12'h04c, 32'h0abc);
        wr(12'h00c, 32'h008);
        wr(12'h008, 32'h1);
        ev <= 10'h00c;
        @(posedge clk_sys);
        ev <= 10'h000;
        n = 0;
        while (irq_take.valid !== 1'b1 && n < 10) begin
            @(posedge clk_sys);
            n++;
        end
        chk("pick", {irq_take.src, irq_take.vector}, 32'h30abc);
        n = 0;
        while ((irq_take.valid !== 1'b1 || irq_take.src !== 4'h2) && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        chk("nested order", {irq_take.src, irq_take.vector}, 32'h21234);
        repeat (30) @(posedge clk_sys);
        wr(12'h008, 32'h0);
        wr(12'h00c, 32'h0);
        wr(12'h000, 32'h1ff);
    endtask
    task automatic t_halt();
        logic r;
        logic seen;
        wr(12'h004, 32'h004);
        wr(12'h008, 32'h10);
        cmd(1'b0, 1'b1, r);
        mode_is(standby_pkg::MODE_HALT);
        pulse(10'h008);
        mode_is(standby_pkg::MODE_HALT);
        ev <= 10'h200;
        @(posedge clk_sys);
        ev <= 10'h000;
        seen = 1'b0;
        repeat (3) begin
            @(posedge clk_sys);
            seen = seen | wd_rst;
        end
        chk("watchdog", 32'(seen), 32'h1);
        pulse(10'h004);
        mode_is(standby_pkg::MODE_RUN);
        wr(12'h008, 32'h0);
        wr(12'h000, 32'h1ff);
    endtask
    task automatic t_stop();
        logic r;
        logic [2:0] pr;
        on_subclock <= 1'b1;
        cmd(1'b1, 1'b0, r);
        chk("refused", 32'(r), 32'h1);
        mode_is(standby_pkg::MODE_RUN);
        on_subclock <= 1'b0;
        wr(12'h004, 32'h002);
        cmd(1'b1, 1'b0, r);
        mode_is(standby_pkg::MODE_STOP);
        pr = {run_en.ser_run, run_en.tev_run, run_en.clkt_run};
        chk("stop periph", 32'(pr), 32'h0);
        wr(12'h008, 32'he);
        pr = {run_en.ser_run, run_en.tev_run, run_en.clkt_run};
        chk("stop ext clk", 32'(pr), 32'h7);
        wr(12'h008, 32'h0);
        pulse(10'h082);
        mode_is(standby_pkg::MODE_STOP);
        wr(12'h010, 32'h4);
        chk("filter bypass", 32'(run_en.filt_run), 32'h1);
        pulse(10'h082);
        mode_is(standby_pkg::MODE_RUN);
        wr(12'h000, 32'h1ff);
        cmd(1'b1, 1'b0, r);
        mode_is(standby_pkg::MODE_STOP);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        mode_is(standby_pkg::MODE_RUN);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(12'h010, 32'h0);
    endtask
    initial begin
        rst_b = 1'b0;
        {psel, penable, pwrite, on_subclock, stop_w, halt_w} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        ev = 10'h000;
        pins = 2'b00;
        ack_w = 4'h0;
        mismatches = 0;
        n_checks = 0;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_flags();
        t_vector();
        t_halt();
        t_stop();
        print_verdict();
    end
endmodule
